//--- ldsb_consts.svh
// Offsets, field positions and reset values for the status bank
// Overview of operation
// - Bit 7 set after init only if stored configuration checksum valid.
// - Init-complete bit 6 set once power-up configuration load finishes.
// - Link status bit 6 follows the remote receiver lock report.
// - Link-lost bit 4 sets on valid change; fault clear or PLL loss clears.
// - Link status bit 3 sets on self-test error in self-test mode; tally holds their number.
// - Link status bit 2 shows fast PLL lock, reset value 1.
// - CRC bit 1 sets on errors while backlink valid; fault clear clears.
// - Link status bit 0 high while backlink valid, reset value 1.
// - Pin level field bit n returns general-purpose pin n.
// - Pin level bit updates only while its pin is an input, else holds.
// - Eight-bit self-test CRC error tally readable at index 0x54.
// - Sixteen-bit backlink CRC count, low byte 0x55, high byte 0x56.
// - Alarm bits 5, 4 flag temperature over, under limit; clear on read.
// - Alarm bits 3, 2 flag monitor B over, under limit; clear on read.
// - Alarm bits 1, 0 flag monitor A over, under limit; clear on read.
// - Monitor A bits 6:4 hold peak while over limit; read clears to zero.
// - Monitor A bits 2:0 keep trough while under; reset and read give 7.
// - Monitor B bits 6:4 hold peak while over limit; read clears to zero.
// - Monitor B bits 2:0 keep trough while under; reset and read give 7.
// - Writing 1 to control bit 3 clears CRC fault state; bit self-clears.
// - Writing 1 to control bit 5 clears self-test tally; bit self-clears.
`ifndef LDSB_CONSTS_SVH
`define LDSB_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define LDSB_IDX_BC_CTRL 8'h49
`define LDSB_IDX_INIT 8'h51
`define LDSB_IDX_LINK 8'h52
`define LDSB_IDX_PINS 8'h53
`define LDSB_IDX_BIST 8'h54
`define LDSB_IDX_CRC_LO 8'h55
`define LDSB_IDX_CRC_HI 8'h56
`define LDSB_IDX_ALARM 8'h57
`define LDSB_IDX_VOLT_A 8'h58
`define LDSB_IDX_VOLT_B 8'h59

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LDSB_BIT_CKSUM 7
`define LDSB_BIT_INIT 6
`define LDSB_BIT_RX_LOCK 6
`define LDSB_BIT_LOST 4
`define LDSB_BIT_BIST 3
`define LDSB_BIT_PLL 2
`define LDSB_BIT_CRC 1
`define LDSB_BIT_VALID 0
`define LDSB_BIT_TALLY_CLR 5
`define LDSB_BIT_RSVD_RW 4
`define LDSB_BIT_CRC_CLR 3
`define LDSB_BIT_T_HI 5
`define LDSB_BIT_T_LO 4
`define LDSB_PEAK_LSB 4
`define LDSB_TROUGH_LSB 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LDSB_RST_PEAK 3'h0
`define LDSB_RST_TROUGH 3'h7
`define LDSB_RST_PLL 1'h1
`define LDSB_RST_VALID 1'h1

`endif

//--- ldsb_pkg.sv
// Types shared by the link diagnostic status bank
package ldsb_pkg;

  // One voltage monitor: present reading and limit comparisons
  typedef struct packed {
    logic [2:0] reading;
    logic over;
    logic under;
  } ldsb_mon_type;

  // Link-side status inputs
  typedef struct packed {
    logic remote_lock;
    logic backlink_valid;
    logic fast_pll_locked;
    logic crc_error;
    logic selftest_mode;
    logic selftest_error;
  } ldsb_link_type;

  // Power-up initialisation report
  typedef struct packed {
    logic init_done;
    logic config_checksum_ok;
  } ldsb_init_type;

endpackage

//--- ldsb_bank.sv
// Link diagnostic status bank with APB register port
`timescale 1ns/10ps
`include "ldsb_consts.svh"

module ldsb_bank #(
  parameter int PINS = 4,
  parameter int MONS = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ldsb_pkg::ldsb_init_type init_in,
  input wire ldsb_pkg::ldsb_link_type link_in,
  input wire logic [PINS-1:0] pin_levels,
  input wire logic [PINS-1:0] pin_is_input,
  input wire logic temp_over_limit,
  input wire logic temp_under_limit,
  input wire ldsb_pkg::ldsb_mon_type [MONS-1:0] mon_in,
  output logic [2:0] link_detect_timer
);
  import ldsb_pkg::*;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Word index of an access; low two address bits are ignored
  function automatic logic [7:0] word_index(input logic [31:0] a);
    word_index = a[9:2];
  endfunction

  // True when an index names a register of this bank
  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i == `LDSB_IDX_BC_CTRL) ||
                ((i >= `LDSB_IDX_INIT) && (i <= `LDSB_IDX_VOLT_B));
  endfunction

  logic [7:0] idx;
  logic rd_take;
  logic wr_done;
  logic done;
  logic rd_clr_alarm;
  logic rd_clr_mon [MONS];
  logic rd_crc_lo;

  assign idx = word_index(paddr);
  // Data is captured one cycle before completion; read side effects go here
  assign rd_take = psel & penable & ~pready & ~pwrite;
  assign done = psel & penable & pready;
  assign wr_done = done & pwrite & (idx == `LDSB_IDX_BC_CTRL);
  assign rd_clr_alarm = rd_take & (idx == `LDSB_IDX_ALARM);
  assign rd_clr_mon[0] = rd_take & (idx == `LDSB_IDX_VOLT_A);
  assign rd_clr_mon[1] = rd_take & (idx == `LDSB_IDX_VOLT_B);
  assign rd_crc_lo = rd_take & (idx == `LDSB_IDX_CRC_LO);

  // ----------------------------------------------------------------------
  // Back-channel control: self-clearing clear strobes and timer field
  // ----------------------------------------------------------------------
  logic crc_clr_r;
  logic tally_clr_r;
  logic rsvd_rw_r;
  logic [2:0] timer_r;

  // Strobes last one cycle, so the bit reads back 0 right after the write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crc_clr_r <= 1'b0;
      tally_clr_r <= 1'b0;
      rsvd_rw_r <= 1'b0;
      timer_r <= 3'h0;
    end else begin
      crc_clr_r <= wr_done & pwdata[`LDSB_BIT_CRC_CLR];
      tally_clr_r <= wr_done & pwdata[`LDSB_BIT_TALLY_CLR];
      if (wr_done) begin
        rsvd_rw_r <= pwdata[`LDSB_BIT_RSVD_RW];
        timer_r <= pwdata[2:0];
      end
    end
  end

  // Timer value is handed to the link detector outside this bank
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_detect_timer <= 3'h0;
    end else begin
      link_detect_timer <= timer_r;
    end
  end

  // ----------------------------------------------------------------------
  // Initialisation status
  // ----------------------------------------------------------------------
  logic init_done_r;
  logic cksum_ok_r;

  // Sticky: once init has finished the result stays until reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      init_done_r <= 1'b0;
      cksum_ok_r <= 1'b0;
    end else if (init_in.init_done && !init_done_r) begin
      init_done_r <= 1'b1;
      cksum_ok_r <= init_in.config_checksum_ok;
    end
  end

  // ----------------------------------------------------------------------
  // Link health
  // ----------------------------------------------------------------------
  logic rx_lock_r;
  logic valid_r;
  logic pll_r;
  logic lost_r;
  logic crc_flag_r;
  logic bist_flag_r;
  logic crc_event;
  logic bist_event;

  assign crc_event = link_in.crc_error & link_in.backlink_valid;
  assign bist_event = link_in.selftest_error & link_in.selftest_mode;

  // Live levels, registered once; valid_r also serves as change detector
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_lock_r <= 1'b0;
      valid_r <= `LDSB_RST_VALID;
      pll_r <= `LDSB_RST_PLL;
    end else begin
      rx_lock_r <= link_in.remote_lock;
      valid_r <= link_in.backlink_valid;
      pll_r <= link_in.fast_pll_locked;
    end
  end

  // Lost flag: a fresh change outranks a clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lost_r <= 1'b0;
    end else if (link_in.backlink_valid != valid_r) begin
      lost_r <= 1'b1;
    end else if (crc_clr_r || (pll_r && !link_in.fast_pll_locked)) begin
      lost_r <= 1'b0;
    end
  end

  // CRC fault flag, set wins over clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crc_flag_r <= 1'b0;
    end else if (crc_event) begin
      crc_flag_r <= 1'b1;
    end else if (crc_clr_r) begin
      crc_flag_r <= 1'b0;
    end
  end

  // Self-test error flag follows the tally and clears with it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bist_flag_r <= 1'b0;
    end else if (bist_event) begin
      bist_flag_r <= 1'b1;
    end else if (tally_clr_r) begin
      bist_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Error counters
  // ----------------------------------------------------------------------
  logic [7:0] tally_r;
  logic [15:0] crc_cnt_r;
  logic [7:0] crc_hi_shadow_r;

  // Self-test tally saturates so a long run never reads as few errors
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tally_r <= 8'h00;
    end else if (bist_event) begin
      if (tally_clr_r) begin
        tally_r <= 8'h01;
      end else if (tally_r != 8'hFF) begin
        tally_r <= tally_r + 8'h01;
      end
    end else if (tally_clr_r) begin
      tally_r <= 8'h00;
    end
  end

  // Backlink CRC count, saturating, cleared with the CRC fault state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crc_cnt_r <= 16'h0000;
    end else if (crc_event) begin
      if (crc_clr_r) begin
        crc_cnt_r <= 16'h0001;
      end else if (crc_cnt_r != 16'hFFFF) begin
        crc_cnt_r <= crc_cnt_r + 16'h0001;
      end
    end else if (crc_clr_r) begin
      crc_cnt_r <= 16'h0000;
    end
  end

  // Reading the low byte freezes the high byte for the next read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crc_hi_shadow_r <= 8'h00;
    end else if (rd_crc_lo) begin
      crc_hi_shadow_r <= crc_cnt_r[15:8];
    end
  end

  // ----------------------------------------------------------------------
  // General-purpose pin levels
  // ----------------------------------------------------------------------
  logic [PINS-1:0] pins_r;

  // Output pins keep their last sampled input level
  generate
    for (genvar p = 0; p < PINS; p++) begin : g_pin
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pins_r[p] <= 1'b0;
        end else if (pin_is_input[p]) begin
          pins_r[p] <= pin_levels[p];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Temperature alarm flags
  // ----------------------------------------------------------------------
  logic t_hi_r;
  logic t_lo_r;

  // A level still present at the read re-sets the flag at once
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      t_hi_r <= 1'b0;
      t_lo_r <= 1'b0;
    end else begin
      t_hi_r <= temp_over_limit | (t_hi_r & ~rd_clr_alarm);
      t_lo_r <= temp_under_limit | (t_lo_r & ~rd_clr_alarm);
    end
  end

  // ----------------------------------------------------------------------
  // Voltage monitors: alarm flags and extremes (0 is A, 1 is B)
  // ----------------------------------------------------------------------
  logic [MONS-1:0] over_r;
  logic [MONS-1:0] under_r;
  logic [2:0] peak_r [MONS];
  logic [2:0] trough_r [MONS];

  generate
    for (genvar m = 0; m < MONS; m++) begin : g_mon
      logic [2:0] peak_base;
      logic [2:0] trough_base;
      // Read clears first, a reading in the same cycle still lands
      assign peak_base = rd_clr_mon[m] ? `LDSB_RST_PEAK : peak_r[m];
      assign trough_base = rd_clr_mon[m] ? `LDSB_RST_TROUGH : trough_r[m];

      // Sticky alarm flags, cleared by reading the alarm register
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          over_r[m] <= 1'b0;
          under_r[m] <= 1'b0;
        end else begin
          over_r[m] <= mon_in[m].over
                       | (over_r[m] & ~rd_clr_alarm);
          under_r[m] <= mon_in[m].under
                        | (under_r[m] & ~rd_clr_alarm);
        end
      end

      // Highest reading seen while over the high limit
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          peak_r[m] <= `LDSB_RST_PEAK;
        end else if (mon_in[m].over && (mon_in[m].reading > peak_base)) begin
          peak_r[m] <= mon_in[m].reading;
        end else begin
          peak_r[m] <= peak_base;
        end
      end

      // Lowest reading seen while under the low limit
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          trough_r[m] <= `LDSB_RST_TROUGH;
        end else if (mon_in[m].under &&
                     (mon_in[m].reading < trough_base)) begin
          trough_r[m] <= mon_in[m].reading;
        end else begin
          trough_r[m] <= trough_base;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------------
  logic [7:0] rd_byte;

  // Unused bits read as zero; reserved control bit 4 reads back its last write
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      `LDSB_IDX_BC_CTRL: begin
        rd_byte[`LDSB_BIT_TALLY_CLR] = tally_clr_r;
        rd_byte[`LDSB_BIT_RSVD_RW] = rsvd_rw_r;
        rd_byte[`LDSB_BIT_CRC_CLR] = crc_clr_r;
        rd_byte[2:0] = timer_r;
      end
      `LDSB_IDX_INIT: begin
        rd_byte[`LDSB_BIT_CKSUM] = cksum_ok_r;
        rd_byte[`LDSB_BIT_INIT] = init_done_r;
      end
      `LDSB_IDX_LINK: begin
        rd_byte[`LDSB_BIT_RX_LOCK] = rx_lock_r;
        rd_byte[`LDSB_BIT_LOST] = lost_r;
        rd_byte[`LDSB_BIT_BIST] = bist_flag_r;
        rd_byte[`LDSB_BIT_PLL] = pll_r;
        rd_byte[`LDSB_BIT_CRC] = crc_flag_r;
        rd_byte[`LDSB_BIT_VALID] = valid_r;
      end
      `LDSB_IDX_PINS: rd_byte[PINS-1:0] = pins_r;
      `LDSB_IDX_BIST: rd_byte = tally_r;
      `LDSB_IDX_CRC_LO: rd_byte = crc_cnt_r[7:0];
      `LDSB_IDX_CRC_HI: rd_byte = crc_hi_shadow_r;
      `LDSB_IDX_ALARM: begin
        rd_byte[`LDSB_BIT_T_HI] = t_hi_r;
        rd_byte[`LDSB_BIT_T_LO] = t_lo_r;
        rd_byte[3] = over_r[1];
        rd_byte[2] = under_r[1];
        rd_byte[1] = over_r[0];
        rd_byte[0] = under_r[0];
      end
      `LDSB_IDX_VOLT_A: begin
        rd_byte[6:4] = peak_r[0];
        rd_byte[2:0] = trough_r[0];
      end
      `LDSB_IDX_VOLT_B: begin
        rd_byte[6:4] = peak_r[1];
        rd_byte[2:0] = trough_r[1];
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // APB response: one wait state, then pready with data or error
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= ~is_mapped(idx);
      prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

endmodule // ldsb_bank

//--- ldsb_bank_props.sv
// Concurrent checks on the status bank register port and read values
`timescale 1ns/10ps

module ldsb_bank_props #(
  parameter int PINS = 4,
  parameter int MONS = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire ldsb_pkg::ldsb_init_type init_in,
  input wire ldsb_pkg::ldsb_link_type link_in,
  input wire logic [PINS-1:0] pin_levels,
  input wire logic [PINS-1:0] pin_is_input,
  input wire logic temp_over_limit,
  input wire logic temp_under_limit,
  input wire ldsb_pkg::ldsb_mon_type [MONS-1:0] mon_in,
  input wire logic [2:0] link_detect_timer
);
  import ldsb_pkg::*;
  // ----------
  // Helpers
  // ----------
  logic [7:0] idx;
  logic rd_at;
  logic [2:0] wd3;
  // Index, read beat and timer field of the write data
  assign idx = paddr[9:2];
  assign rd_at = pready && !pwrite;
  assign wd3 = pwdata[2:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Only the control word and the status run are decoded
  function automatic logic mapped(input logic [7:0] i);
    return i == 8'h49 || (i >= 8'h51 && i <= 8'h59);
  endfunction

  // Access start, its single answer beat, quiet link inputs
  sequence acc_first;
    psel && penable && !pready;
  endsequence
  sequence one_beat;
    pready ##1 !pready;
  endsequence
  sequence link_calm;
    $past(link_in) == $past(link_in, 2) &&
      $past(link_in, 2) == $past(link_in, 3);
  endsequence

  // ----------
  // Properties
  // ----------
  chk_one_wait: assert property (acc_first |=> one_beat)
    else $error("answer did not follow one wait state");
  chk_err_decode: assert property (
    pready |-> pslverr == !mapped(idx))
    else $error("error response does not match the index");
  chk_idle_data: assert property (prdata[31:8] == 24'h0 &&
    (pready || prdata == 32'h0))
    else $error("read data not zero outside its beat");
  chk_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  chk_timer_write: assert property (pready && pwrite && idx == 8'h49 |=>
    ##1 link_detect_timer == $past(wd3, 2))
    else $error("timer output does not follow control write");
  chk_live_link: assert property (
    rd_at && idx == 8'h52 ##0 link_calm |->
      prdata[6] == $past(link_in.remote_lock, 2) &&
      prdata[2] == $past(link_in.fast_pll_locked, 2) &&
      prdata[0] == $past(link_in.backlink_valid, 2))
    else $error("live link bits differ from inputs");
  chk_init_sticky: assert property (
    rd_at && idx == 8'h51 && $past(init_in.init_done, 3) |-> prdata[6])
    else $error("init done flag missing");
  chk_alarm_live: assert property (
    rd_at && idx == 8'h57 && $past(temp_over_limit, 2) &&
      $past(temp_over_limit, 3) |-> prdata[5])
    else $error("temperature alarm missing while present");

endmodule // ldsb_bank_props

bind ldsb_bank ldsb_bank_props #(.PINS(PINS), .MONS(MONS)) ldsb_bank_props_inst (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .init_in(init_in), .link_in(link_in),
  .pin_levels(pin_levels), .pin_is_input(pin_is_input),
  .temp_over_limit(temp_over_limit), .temp_under_limit(temp_under_limit),
  .mon_in(mon_in), .link_detect_timer(link_detect_timer)
);

//--- ldsb_bank_bench.sv
// Self-checking bench for the link diagnostic status bank
`timescale 1ns/10ps

module ldsb_bank_bench;
  import ldsb_pkg::*;
  // ----------
  // Signals
  // ----------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ldsb_init_type init_in = '0;
  ldsb_link_type link_in = 6'h18; // Fast PLL locked, backlink valid
  logic [3:0] pin_levels = 4'h0;
  logic [3:0] pin_is_input = 4'hF;
  logic t_over = 1'b0;
  logic t_under = 1'b0;
  ldsb_mon_type [1:0] mon_in = '0;
  logic [2:0] link_detect_timer;
  logic [31:0] d;
  logic serr;
  int n_fail = 0;
  int checks_done = 0;

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  ldsb_bank ldsb_bank_inst (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .init_in(init_in), .link_in(link_in),
    .pin_levels(pin_levels), .pin_is_input(pin_is_input),
    .temp_over_limit(t_over), .temp_under_limit(t_under), .mon_in(mon_in),
    .link_detect_timer(link_detect_timer)
  );

  // ----------
  // Helpers
  // ----------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One APB transfer, held until pready; one idle cycle after it
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] v);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {22'h0, i, 2'b00};
    pwdata <= {24'h0, v};
    @(posedge clk);
    penable <= 1'b1;
    // No local limit: a missing answer is left to the watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    d = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] i);
    apb(1'b0, i, 8'h00);
  endtask

  task automatic do_reset();
    rstn <= 1'b0;
    tick(6);
    rstn <= 1'b1;
    tick(1);
  endtask

  // ----------
  // Scenarios
  // ----------
  // Reset view of the whole status run, an unmapped index, a read-only write
  task automatic s_reset_values();
    logic [7:0] exp [9] = '{8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h07, 8'h07};
    for (int i = 0; i < 9; i++) begin
      rd(8'h51 + i[7:0]);
      check(d, {24'h0, exp[i]});
      check({31'h0, serr}, 32'h0);
    end
    rd(8'h50);
    check({31'h0, serr}, 32'h1);
    apb(1'b1, 8'h54, 8'h5A);
    rd(8'h54);
    check(d, 32'h0);
  endtask

  // Control word read-back; timer field reaches its output a cycle later
  task automatic s_ctrl();
    apb(1'b1, 8'h49, 8'h15);
    rd(8'h49);
    check(d, 32'h15);
    check({29'h0, link_detect_timer}, 32'h5);
    apb(1'b1, 8'h49, 8'h00);
    tick(1);
    check({29'h0, link_detect_timer}, 32'h0);
  endtask

  // Checksum latched once at the first init-done cycle; reset mid-run
  task automatic s_init();
    init_in <= 2'b10;
    tick(2);
    init_in <= 2'b11; // Late checksum change must not count
    tick(2);
    rd(8'h51);
    check(d, 32'h40);
    init_in <= 2'b00;
    do_reset();
    rd(8'h51);
    check(d, 32'h00);
    init_in <= 2'b11;
    tick(2);
    rd(8'h51);
    check(d, 32'hC0);
  endtask

  // Remote lock, link-lost set on change, cleared by PLL loss and clear
  task automatic s_link();
    link_in.remote_lock <= 1'b1;
    tick(3);
    rd(8'h52);
    check(d, 32'h45);
    link_in.backlink_valid <= 1'b0;
    tick(3);
    rd(8'h52);
    check(d, 32'h54);
    link_in.fast_pll_locked <= 1'b0;
    tick(3);
    rd(8'h52);
    check(d, 32'h40);
    link_in.fast_pll_locked <= 1'b1;
    link_in.backlink_valid <= 1'b1;
    tick(3);
    rd(8'h52);
    check(d, 32'h55);
    apb(1'b1, 8'h49, 8'h08);
    rd(8'h52);
    check(d, 32'h45);
  endtask

  // CRC counted only with valid link; saturation; fault clear
  task automatic s_crc();
    link_in.crc_error <= 1'b1;
    tick(3);
    link_in.crc_error <= 1'b0;
    tick(2);
    link_in.backlink_valid <= 1'b0;
    tick(2);
    link_in.crc_error <= 1'b1;
    tick(3);
    link_in.crc_error <= 1'b0;
    tick(2);
    link_in.backlink_valid <= 1'b1;
    tick(3);
    rd(8'h55);
    check(d, 32'h03);
    rd(8'h56);
    check(d, 32'h00);
    rd(8'h52);
    check(d, 32'h57);
    link_in.crc_error <= 1'b1;
    tick(65600);
    rd(8'h55);
    check(d, 32'hFF);
    rd(8'h56);
    check(d, 32'hFF);
    link_in.crc_error <= 1'b0;
    tick(2);
    apb(1'b1, 8'h49, 8'h08);
    rd(8'h55);
    check(d, 32'h00);
    rd(8'h52);
    check(d, 32'h45);
    rd(8'h49);
    check(d, 32'h00);
  endtask

  // Self-test errors counted only in self-test mode; saturation; clear
  task automatic s_bist();
    link_in.selftest_error <= 1'b1;
    tick(4);
    link_in.selftest_error <= 1'b0;
    tick(2);
    link_in.selftest_mode <= 1'b1;
    tick(2);
    link_in.selftest_error <= 1'b1;
    tick(5);
    link_in.selftest_error <= 1'b0;
    tick(2);
    rd(8'h54);
    check(d, 32'h05);
    rd(8'h52);
    check(d, 32'h4D);
    link_in.selftest_error <= 1'b1;
    tick(300);
    link_in.selftest_error <= 1'b0;
    tick(2);
    rd(8'h54);
    check(d, 32'hFF);
    apb(1'b1, 8'h49, 8'h20);
    rd(8'h54);
    check(d, 32'h00);
    rd(8'h52);
    check(d, 32'h45);
    rd(8'h49);
    check(d, 32'h00);
  endtask

  // Pin levels follow only the pins set as inputs
  task automatic s_pins();
    pin_levels <= 4'hA;
    tick(3);
    rd(8'h53);
    check(d, 32'h0A);
    pin_is_input <= 4'h3;
    pin_levels <= 4'h5;
    tick(3);
    rd(8'h53);
    check(d, 32'h09);
  endtask

  // Peak and trough capture per monitor, alarms, clear on read
  task automatic s_volt();
    logic [2:0] seq [6] = '{3'h3, 3'h5, 3'h2, 3'h4, 3'h1, 3'h6};
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 6; k++) begin
        mon_in[m] <= '{seq[k], k < 3, k >= 3};
        tick(1);
      end
      mon_in[m] <= '0;
      tick(2);
      rd(8'h57);
      check(d, 32'h3 << (2 * m));
      rd(8'h58 + m[7:0]);
      check(d, 32'h51);
      rd(8'h57);
      check(d, 32'h00);
      rd(8'h58 + m[7:0]);
      check(d, 32'h07);
    end
  endtask

  // Temperature alarms; a condition still present sets again after a read
  task automatic s_temp();
    t_under <= 1'b1;
    tick(2);
    t_under <= 1'b0;
    t_over <= 1'b1;
    tick(3);
    rd(8'h57);
    check(d, 32'h30);
    t_over <= 1'b0;
    tick(2);
    rd(8'h57);
    check(d, 32'h20);
    rd(8'h57);
    check(d, 32'h00);
  endtask

  // ----------
  // Run control
  // ----------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    do_reset();
    s_reset_values();
    s_ctrl();
    s_init();
    s_link();
    s_crc();
    s_bist();
    s_pins();
    s_volt();
    s_temp();
    end_sim();
  end

  // Watchdog well beyond the roughly 66k cycles the run needs
  initial begin
    #900000;
    n_fail++;
    end_sim();
  end

endmodule // ldsb_bank_bench
